// ===== dv/flbf_formatter_assertions.sv
// assertion checker for the fault-log reply formatter
`timescale 1ns/10ps
`default_nettype none

module flbf_formatter_assertions
    import flbf_pkg::*;
(
    input wire logic            clock_i,
    input wire logic            reset_i,
    input wire logic            ce_i,
    input wire logic            start_i,
    input wire flbf_record_type record_i,
    input wire logic            log_rd_o,
    input wire logic [7:0]      log_index_o,
    input wire logic [5:0]      log_pos_o,
    input wire logic            busy_o,
    input wire logic            reply_valid_o,
    input wire flbf_beat_type   reply_beat_o,
    input wire logic            reply_ready_i
);
    // ----------------
    // helper state and checks
    // ----------------
    logic [7:0] cap_ptr;
    logic [5:0] prev_pos;
    logic [7:0] prev_idx;
    logic [8:0] last_num;

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (reset_i);

    // only an accepted start moves the pointer
    always_ff @(posedge clock_i)
    begin
        if (ce_i && start_i && !busy_o)
            cap_ptr <= record_i.ptr;
        if (ce_i && log_rd_o)
            prev_pos <= log_pos_o;
        if (ce_i && log_rd_o)
            prev_idx <= log_index_o;
        if (reset_i)
            last_num <= 9'h000;
        else if (ce_i && reply_valid_o && reply_ready_i)
            last_num <= reply_beat_o.num;
    end

    sequence s_take;
        ce_i && start_i && !busy_o && !reply_valid_o;
    endsequence
    sequence s_count_out;
        reply_valid_o && reply_beat_o.num == 9'h000 && reply_beat_o.data == 8'hff;
    endsequence
    property p_open;
        s_take |=> busy_o ##[2:3] s_count_out;
    endproperty
    property p_gap;
        ce_i && log_rd_o |=> !log_rd_o [*2];
    endproperty
    property p_first_pos;
        log_rd_o && log_index_o == 8'h00
            |-> log_pos_o == ((cap_ptr > 8'h23) ? 6'h23 : cap_ptr[5:0]);
    endproperty
    property p_step;
        log_rd_o && log_index_o != 8'h00 |-> log_index_o == prev_idx + 8'h01
            && log_index_o <= 8'hb6
            && log_pos_o == ((prev_pos == 6'h00) ? 6'h23 : prev_pos - 6'h01);
    endproperty
    property p_last;
        reply_valid_o |-> reply_beat_o.last == (reply_beat_o.num == 9'h0ff);
    endproperty
    property p_hold;
        reply_valid_o && !reply_ready_i && ce_i |=> reply_valid_o && $stable(reply_beat_o);
    endproperty
    property p_num;
        reply_valid_o && reply_beat_o.num != 9'h000 |-> reply_beat_o.num == last_num + 9'h001;
    endproperty
    property p_resv;
        reply_valid_o && reply_beat_o.num >= 9'h0ef |-> reply_beat_o.data == 8'h00;
    endproperty

    a_open: assert property (p_open) else $error("reply did not open with count beat");
    a_gap: assert property (p_gap) else $error("store reads too close");
    a_first_pos: assert property (p_first_pos) else $error("first loop position wrong");
    a_step: assert property (p_step) else $error("loop position step wrong");
    a_last: assert property (p_last) else $error("last flag misplaced");
    a_hold: assert property (p_hold) else $error("beat changed while stalled");
    a_num: assert property (p_num) else $error("byte number skipped");
    a_resv: assert property (p_resv) else $error("reserved byte not zero");
endmodule : flbf_formatter_assertions

bind flbf_formatter flbf_formatter_assertions flbf_formatter_assertions_inst (
    .clock_i(clock_i), .reset_i(reset_i), .ce_i(ce_i), .start_i(start_i),
    .record_i(record_i), .log_rd_o(log_rd_o), .log_index_o(log_index_o),
    .log_pos_o(log_pos_o), .busy_o(busy_o), .reply_valid_o(reply_valid_o),
    .reply_beat_o(reply_beat_o), .reply_ready_i(reply_ready_i)
);
`default_nettype wire

// ===== dv/flbf_host_model.sv
// loop store and stalling host beside the fault-log reply formatter
`timescale 1ns/10ps
`default_nettype none

module flbf_host_model (
    input  wire logic       clock_i,
    input  wire logic       log_rd_i,
    input  wire logic [5:0] log_pos_i,
    input  wire logic       slow_i,
    output logic      [7:0] log_data_o,
    output logic            ready_o
);
    // ----------------
    // store answers one cycle after a read
    // ----------------
    logic [1:0] phase = 2'd0;

    initial log_data_o = 8'h5a;

    // toggles off the answer cycle, so a late sample shows
    always @(posedge clock_i)
    begin
        if (log_rd_i)
            log_data_o <= {2'b00, log_pos_i} ^ 8'ha5;
        else
            log_data_o <= ~log_data_o;
    end

    // slow host takes one beat in four, enough to fill the fifo
    always @(negedge clock_i)
    begin
        phase <= phase + 2'd1;
        ready_o <= !slow_i || (phase == 2'd3);
    end
endmodule : flbf_host_model
`default_nettype wire

// ===== dv/test_fault_log_block_formatter.sv
// self-checking bench for the fault-log reply formatter
`timescale 1ns/10ps
`default_nettype none

module test_fault_log_block_formatter
    import flbf_pkg::*;
;
    // ----------------
    // design, far side and checking
    // ----------------
    logic            clock_i = 1'b0;
    logic            reset_i = 1'b1;
    logic            ce_i = 1'b1;
    logic            start_i = 1'b0;
    flbf_record_type record_i;
    logic            fault_event_i = 1'b0;
    logic            first_fault_i = 1'b0;
    logic            first_clear_i = 1'b0;
    logic            log_rd_o;
    logic [7:0]      log_index_o;
    logic [5:0]      log_pos_o;
    logic [7:0]      log_data_i;
    logic            busy_o;
    logic            reply_valid_o;
    flbf_beat_type   reply_beat_o;
    logic            reply_ready_i;
    logic            slow = 1'b0;
    logic [40:0]     st;
    logic [7:0]      tk;
    int              num_errors = 0;
    int              check_count = 0;
    int              cyc = 0;
    flbf_beat_type   beats[$];

    flbf_formatter #(.TICK_CYCLES(4), .FIFO_DEPTH(8)) flbf_formatter_inst (
        .clock_i(clock_i), .reset_i(reset_i), .ce_i(ce_i), .start_i(start_i),
        .record_i(record_i), .fault_event_i(fault_event_i), .first_fault_i(first_fault_i),
        .first_clear_i(first_clear_i), .log_rd_o(log_rd_o), .log_index_o(log_index_o),
        .log_pos_o(log_pos_o), .log_data_i(log_data_i), .busy_o(busy_o),
        .reply_valid_o(reply_valid_o), .reply_beat_o(reply_beat_o),
        .reply_ready_i(reply_ready_i)
    );
    flbf_host_model flbf_host_model_inst (
        .clock_i(clock_i), .log_rd_i(log_rd_o), .log_pos_i(log_pos_o),
        .slow_i(slow), .log_data_o(log_data_i), .ready_o(reply_ready_i)
    );

    always #5 clock_i = ~clock_i;
    always @(posedge clock_i) cyc <= reset_i ? 0 : cyc + int'(ce_i);
    always @(posedge clock_i)
        if (!reset_i && ce_i && reply_valid_o === 1'b1 && reply_ready_i === 1'b1)
            beats.push_back(reply_beat_o);

    function automatic logic [7:0] exp_byte(input int b, input flbf_record_type r,
                                            input logic [40:0] s, input logic [7:0] t);
        int p;
        p = ((int'((r.ptr > 8'h23) ? 8'h23 : r.ptr) - (b - 55)) % 36 + 36) % 36;
        if (b == 0) return r.ptr;
        if (b >= 2 && b <= 6) return s[(b - 2) * 8 +: 8];
        if (b == 7) return {7'h00, s[40]};
        if (b == 8) return r.first_fault[7:0];
        if (b == 9) return r.first_fault[15:8];
        if (b == 10) return t;
        if (b >= 11 && b <= 46) return r.peak_min[(b - 11) / 2][((b - 11) % 2) * 8 +: 8];
        if (b >= 47 && b <= 54) return r.status[b - 47];
        if (b >= 55 && b <= 237 && p != 18) return 8'(p) ^ 8'ha5;
        return 8'h00;
    endfunction : exp_byte

    task automatic check_val(input logic [40:0] got, input logic [40:0] exp, input int tol);
        check_count++;
        if (^got === 1'bx || ((got > exp) ? got - exp : exp - got) > 41'(tol))
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: value %0h expected %0h", $time, got, exp);
        end
    endtask : check_val

    task automatic check_beat(input flbf_beat_type got, input flbf_beat_type exp);
        check_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: beat %h expected %h", $time, got, exp);
        end
    endtask : check_beat

    task automatic pulse(input int k);
        @(negedge clock_i);
        {first_clear_i, first_fault_i, fault_event_i} = 3'(1 << k);
        @(negedge clock_i);
        {first_clear_i, first_fault_i, fault_event_i} = 3'b000;
    endtask : pulse

    // a second start mid-reply is refused
    task automatic do_reply(input logic [7:0] ptr, input logic slow_req);
        flbf_record_type r;
        flbf_beat_type   e;
        logic [40:0]     g;
        int              n;
        r = record_i;
        r.ptr = ptr;
        beats.delete();
        @(negedge clock_i);
        slow = slow_req;
        record_i = r;
        start_i = 1'b1;
        @(negedge clock_i);
        start_i = 1'b0;
        for (n = 0; n < 20; n++)
        begin
            @(negedge clock_i);
            ce_i = (n < 6) || n[0];
        end
        record_i.ptr = ptr ^ 8'h01;
        start_i = 1'b1;
        @(negedge clock_i);
        start_i = 1'b0;
        for (n = 0; n < 6000 && (beats.size() < 256 || busy_o !== 1'b0); n++)
            @(negedge clock_i);
        repeat (10) @(negedge clock_i);
        check_val(41'(beats.size()), 41'd256, 0);
        if (beats.size() == 256)
        begin
            g = {beats[8].data[0], beats[7].data, beats[6].data, beats[5].data,
                 beats[4].data, beats[3].data};
            check_val(g, st, 0);
            check_val(41'(beats[11].data), 41'(tk), 0);
            st = g;
            tk = beats[11].data;
            for (int i = 0; i < 256; i++)
            begin
                e.data = (i == 0) ? 8'hff : exp_byte(i - 1, r, st, tk);
                e.num = 9'(i);
                e.last = (i == 255);
                check_beat(beats[i], e);
            end
        end
    endtask : do_reply

    task automatic test_reset_idle();
        check_val({40'h0, busy_o}, 41'h0, 0);
        check_val({40'h0, reply_valid_o}, 41'h0, 0);
        check_val({40'h0, log_rd_o}, 41'h0, 0);
    endtask : test_reset_idle

    task automatic test_plain_read();
        do_reply(8'h09, 1'b0);
    endtask : test_plain_read

    task automatic test_stamped_wrap();
        int ev;
        repeat (300) @(negedge clock_i);
        pulse(0);
        ev = cyc;
        repeat (40) @(negedge clock_i);
        pulse(1);
        st = 41'((ev - 1) / 4);
        tk = 8'((cyc - 1) / 4);
        do_reply(8'h00, 1'b1);
    endtask : test_stamped_wrap

    // a held tick ignores further faults until re-armed
    task automatic test_first_rearm();
        pulse(1);
        do_reply(8'h23, 1'b0);
        pulse(2);
        repeat (100) @(negedge clock_i);
        pulse(1);
        tk = 8'((cyc - 1) / 4);
        do_reply(8'h40, 1'b1);
    endtask : test_first_rearm

    task automatic results();
        $display("errors %0d, checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : results

    initial
    begin
        record_i = '0;
        record_i.first_fault = 16'hc3b4;
        for (int i = 0; i < 18; i++)
            record_i.peak_min[i] = {8'(8'h20 + i), 8'(8'h40 + i)};
        for (int i = 0; i < 8; i++)
            record_i.status[i] = 8'(8'h60 + i);
        st = '0;
        tk = '0;
        repeat (8) @(negedge clock_i);
        reset_i = 1'b0;
        test_reset_idle();
        test_plain_read();
        test_stamped_wrap();
        test_first_rearm();
        results();
    end

    initial
    begin
        repeat (30000) @(posedge clock_i);
        num_errors++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        results();
    end
endmodule : test_fault_log_block_formatter
`default_nettype wire

// ===== rtl/flbf_defs.svh
// constants for the fault-log block reply formatter
`ifndef FLBF_DEFS_SVH
`define FLBF_DEFS_SVH

// ----------------
// reply layout, table byte numbers counted from zero
// ----------------
`define FLBF_COUNT_BYTE    8'hff
`define FLBF_PTR_OFS       8'h00
`define FLBF_ZERO_OFS      8'h01
`define FLBF_TS_OFS        8'h02
`define FLBF_TS_LAST       8'h07
`define FLBF_FF_LO_OFS     8'h08
`define FLBF_FF_HI_OFS     8'h09
`define FLBF_TICK_OFS      8'h0a
`define FLBF_PM_OFS        8'h0b
`define FLBF_PM_LAST       8'h2e
`define FLBF_ST_OFS        8'h2f
`define FLBF_PRE_LAST      8'h36
`define FLBF_LOOP_LAST     8'hed
`define FLBF_RESV_LAST     8'hfe
`define FLBF_NUM_BASE      9'h001
`define FLBF_COUNT_NUM     9'h000

// ----------------
// cyclical loop positions
// ----------------
`define FLBF_LOOP_TOP      6'h23
`define FLBF_LOOP_BOTTOM   6'h00
`define FLBF_ZERO_POS      6'h12
`define FLBF_ZERO_BYTE     8'h00

// ----------------
// shared tick timing
// ----------------
`define FLBF_TICK_US       200
`define FLBF_CLK_MHZ       100
`define FLBF_TS_WIDTH      41

`endif

// ===== rtl/flbf_fifo.sv
// small synchronous fifo with a registered output stage
`timescale 1ns/10ps
`default_nettype none

module flbf_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 8
) (
    input  wire logic             clock_i,
    input  wire logic             reset_i,
    input  wire logic             ce_i,
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  in_ready_o,
    output logic                  out_valid_o,
    output logic      [WIDTH-1:0] out_data_o,
    input  wire logic             out_ready_i
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic [AW-1:0]    next_wr_ptr;
    logic [AW-1:0]    next_rd_ptr;
    logic [AW:0]      next_count;
    logic             next_out_valid;
    logic [WIDTH-1:0] next_out_data;
    logic             push;
    logic             pop;

    // ----------------
    // pointer and count update
    // ----------------
    always_comb
    begin
        push           = in_valid_i && (count < (AW+1)'(DEPTH));
        pop            = (count != '0) && (!out_valid_o || out_ready_i);
        next_wr_ptr    = wr_ptr;
        next_rd_ptr    = rd_ptr;
        next_count     = count;
        next_out_valid = out_valid_o;
        next_out_data  = out_data_o;
        if (out_valid_o && out_ready_i)
            next_out_valid = 1'b0;
        if (push)
            next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
        if (pop)
        begin
            next_rd_ptr    = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            next_out_valid = 1'b1;
            next_out_data  = mem[rd_ptr];
        end
        next_count = count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            wr_ptr      <= '0;
            rd_ptr      <= '0;
            count       <= '0;
            out_valid_o <= 1'b0;
            out_data_o  <= '0;
        end
        else if (ce_i)
        begin
            wr_ptr      <= next_wr_ptr;
            rd_ptr      <= next_rd_ptr;
            count       <= next_count;
            out_valid_o <= next_out_valid;
            out_data_o  <= next_out_data;
        end
    end

    // storage has no reset; only written words are ever read
    always_ff @(posedge clock_i)
    begin
        if (ce_i && push)
            mem[wr_ptr] <= in_data_i;
    end

    // full flag is the count itself, so ready never lies
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
            in_ready_o <= 1'b1;
        else if (ce_i)
            in_ready_o <= (next_count < (AW+1)'(DEPTH));
    end

endmodule : flbf_fifo

`default_nettype wire

// ===== rtl/flbf_formatter.sv
// fault-log block reply formatter: preamble, cyclical loop bytes, reserved tail
//
// Behaviour
// - reply byte numbers carried on the stream count from zero at the count byte, so table byte n is number n+1
// - reply opens with byte count 0xFF, then the saved pointer as first data
// - bytes 55 to 237 carry cyclical loop data chosen by the saved pointer
// - byte 55 holds the loop entry at position equal to the saved pointer, or position 35 for pointers above 35
// - every later loop byte holds the entry one position lower, wrapping from position 0 to 35
// - 36 positions, position 18 is a zero byte, words low byte first
// - pointer 9 gives temperature status, then temperature high, then low
// - preamble bytes 0 to 54 laid out pointer, zero, stamp, fault, words, status
// - 41-bit shared timestamp counts 200 us ticks, cleared on reset
// - first-fault tick holds low 8 timestamp bits at the first fault
// - bytes 238 to 254 are reserved and follow the loop data
`include "flbf_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module flbf_formatter
    import flbf_pkg::*;
#(
    parameter int TICK_CYCLES = `FLBF_TICK_US * `FLBF_CLK_MHZ,
    parameter int FIFO_DEPTH  = 8
) (
    input  wire logic            clock_i,
    input  wire logic            reset_i,
    input  wire logic            ce_i,
    input  wire logic            start_i,
    input  wire flbf_record_type record_i,
    input  wire logic            fault_event_i,
    input  wire logic            first_fault_i,
    input  wire logic            first_clear_i,
    output logic                 log_rd_o,
    output logic [7:0]           log_index_o,
    output logic [5:0]           log_pos_o,
    input  wire logic [7:0]      log_data_i,
    output logic                 busy_o,
    output logic                 reply_valid_o,
    output flbf_beat_type        reply_beat_o,
    input  wire logic            reply_ready_i
);

    localparam int TCW = $clog2(TICK_CYCLES + 1);

    // ----------------
    // preamble byte selection
    // ----------------
    function automatic logic [7:0] pre_byte(
        input flbf_record_type                rec,
        input logic [`FLBF_TS_WIDTH-1:0]      stamp,
        input logic [7:0]                     tick,
        input logic [7:0]                     idx
    );
        logic [47:0] wide;
        logic [7:0]  rel;
        logic [15:0] word;
        logic [7:0]  res;
        wide = 48'(stamp);
        rel  = 8'h00;
        word = 16'h0000;
        res  = `FLBF_ZERO_BYTE;
        if (idx == `FLBF_PTR_OFS)
            res = rec.ptr;
        else if (idx == `FLBF_ZERO_OFS)
            res = `FLBF_ZERO_BYTE;
        else if (idx <= `FLBF_TS_LAST)
        begin
            rel = idx - `FLBF_TS_OFS;
            res = wide[rel[2:0]*8 +: 8];
        end
        else if (idx == `FLBF_FF_LO_OFS)
            res = rec.first_fault[7:0];
        else if (idx == `FLBF_FF_HI_OFS)
            res = rec.first_fault[15:8];
        else if (idx == `FLBF_TICK_OFS)
            res = tick;
        else if (idx <= `FLBF_PM_LAST)
        begin
            rel  = idx - `FLBF_PM_OFS;
            word = rec.peak_min[rel[5:1]];
            res  = rel[0] ? word[15:8] : word[7:0];
        end
        else if (idx <= `FLBF_PRE_LAST)
        begin
            rel = idx - `FLBF_ST_OFS;
            res = rec.status[rel[2:0]];
        end
        return res;
    endfunction : pre_byte

    // ----------------
    // shared timestamp and first-fault tick
    // ----------------
    logic [TCW-1:0]             presc;
    logic [`FLBF_TS_WIDTH-1:0]  stamp;
    logic [`FLBF_TS_WIDTH-1:0]  fault_stamp;
    logic [7:0]                 first_fault_tick;
    logic                       tick_held;
    logic [TCW-1:0]             next_presc;
    logic [`FLBF_TS_WIDTH-1:0]  next_stamp;
    logic [`FLBF_TS_WIDTH-1:0]  next_fault_stamp;
    logic [7:0]                 next_first_fault_tick;
    logic                       next_tick_held;

    always_comb
    begin
        next_presc            = presc + 1'b1;
        next_stamp            = stamp;
        next_fault_stamp      = fault_stamp;
        next_first_fault_tick = first_fault_tick;
        next_tick_held        = tick_held;
        if (presc == TCW'(TICK_CYCLES - 1))
        begin
            next_presc = '0;
            next_stamp = stamp + 1'b1;
        end
        if (fault_event_i)
            next_fault_stamp = stamp;
        if (first_clear_i)
            next_tick_held = 1'b0;
        // a fault in the clearing cycle still gets captured
        if (first_fault_i && (!tick_held || first_clear_i))
        begin
            next_first_fault_tick = stamp[7:0];
            next_tick_held        = 1'b1;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            presc            <= '0;
            stamp            <= '0;
            fault_stamp      <= '0;
            first_fault_tick <= 8'h00;
            tick_held        <= 1'b0;
        end
        else if (ce_i)
        begin
            presc            <= next_presc;
            stamp            <= next_stamp;
            fault_stamp      <= next_fault_stamp;
            first_fault_tick <= next_first_fault_tick;
            tick_held        <= next_tick_held;
        end
    end

    // ----------------
    // reply sequencer
    // ----------------
    flbf_state_type  state;
    flbf_state_type  next_state;
    flbf_record_type rec;
    flbf_record_type next_rec;
    logic [7:0]      idx;
    logic [7:0]      next_idx;
    logic [5:0]      next_log_pos;
    logic [7:0]      next_log_index;
    logic            next_log_rd;
    logic            next_busy;
    logic            pend_valid;
    logic            next_pend_valid;
    flbf_beat_type   pend_beat;
    flbf_beat_type   next_pend_beat;
    logic            fifo_in_ready;
    logic            can_load;

    always_comb
    begin
        next_state      = state;
        next_rec        = rec;
        next_idx        = idx;
        next_log_pos    = log_pos_o;
        next_log_index  = log_index_o;
        next_log_rd     = 1'b0;
        next_busy       = busy_o;
        next_pend_valid = pend_valid;
        next_pend_beat  = pend_beat;
        if (pend_valid && fifo_in_ready)
            next_pend_valid = 1'b0;
        // holding slot is free, or empties this cycle
        can_load = !pend_valid || fifo_in_ready;
        case (state)
            FLBF_IDLE:
            begin
                // a start while busy is never seen: only idle listens
                if (start_i)
                begin
                    next_rec   = record_i;
                    next_busy  = 1'b1;
                    next_state = FLBF_COUNT;
                end
            end
            FLBF_COUNT:
            begin
                if (can_load)
                begin
                    next_pend_valid     = 1'b1;
                    next_pend_beat.data = `FLBF_COUNT_BYTE;
                    next_pend_beat.num  = `FLBF_COUNT_NUM;
                    next_pend_beat.last = 1'b0;
                    next_idx            = `FLBF_PTR_OFS;
                    next_state          = FLBF_PRE;
                end
            end
            FLBF_PRE:
            begin
                if (can_load)
                begin
                    next_pend_valid     = 1'b1;
                    next_pend_beat.data = pre_byte(rec, fault_stamp,
                                                   first_fault_tick, idx);
                    next_pend_beat.num  = 9'(idx) + `FLBF_NUM_BASE;
                    next_pend_beat.last = 1'b0;
                    next_idx            = idx + 1'b1;
                    if (idx == `FLBF_PRE_LAST)
                    begin
                        // out-of-range pointer starts from the top
                        next_log_pos   = (rec.ptr > 8'(`FLBF_LOOP_TOP)) ?
                                         `FLBF_LOOP_TOP : rec.ptr[5:0];
                        next_log_index = 8'h00;
                        next_state     = FLBF_LOOP_REQ;
                    end
                end
            end
            FLBF_LOOP_REQ:
            begin
                // wait for an empty slot so the read data is never dropped
                if (!pend_valid)
                begin
                    next_log_rd = 1'b1;
                    next_state  = FLBF_LOOP_WAIT;
                end
            end
            FLBF_LOOP_WAIT:
            begin
                next_state = FLBF_LOOP_DATA;
            end
            FLBF_LOOP_DATA:
            begin
                next_pend_valid     = 1'b1;
                next_pend_beat.data = (log_pos_o == `FLBF_ZERO_POS) ?
                                      `FLBF_ZERO_BYTE : log_data_i;
                next_pend_beat.num  = 9'(idx) + `FLBF_NUM_BASE;
                next_pend_beat.last = 1'b0;
                next_idx            = idx + 1'b1;
                if (idx == `FLBF_LOOP_LAST)
                    next_state = FLBF_RESV;
                else
                begin
                    next_log_index = log_index_o + 1'b1;
                    next_log_pos   = (log_pos_o == `FLBF_LOOP_BOTTOM) ?
                                     `FLBF_LOOP_TOP :
                                     log_pos_o - 1'b1;
                    next_state     = FLBF_LOOP_REQ;
                end
            end
            FLBF_RESV:
            begin
                if (can_load)
                begin
                    next_pend_valid     = 1'b1;
                    next_pend_beat.data = `FLBF_ZERO_BYTE;
                    next_pend_beat.num  = 9'(idx) + `FLBF_NUM_BASE;
                    next_pend_beat.last = (idx == `FLBF_RESV_LAST);
                    next_idx            = idx + 1'b1;
                    if (idx == `FLBF_RESV_LAST)
                    begin
                        next_busy  = 1'b0;
                        next_state = FLBF_IDLE;
                    end
                end
            end
            default:
            begin
                next_busy  = 1'b0;
                next_state = FLBF_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            state       <= FLBF_IDLE;
            rec         <= '0;
            idx         <= 8'h00;
            log_pos_o   <= 6'h00;
            log_index_o <= 8'h00;
            log_rd_o    <= 1'b0;
            busy_o      <= 1'b0;
            pend_valid  <= 1'b0;
            pend_beat   <= '0;
        end
        else if (ce_i)
        begin
            state       <= next_state;
            rec         <= next_rec;
            idx         <= next_idx;
            log_pos_o   <= next_log_pos;
            log_index_o <= next_log_index;
            log_rd_o    <= next_log_rd;
            busy_o      <= next_busy;
            pend_valid  <= next_pend_valid;
            pend_beat   <= next_pend_beat;
        end
    end

    // ----------------
    // output buffer toward the bus engine
    // ----------------
    // back-pressure from the engine stalls the sequencer via can_load
    flbf_fifo #(
        .WIDTH($bits(flbf_beat_type)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock_i    (clock_i),
        .reset_i    (reset_i),
        .ce_i       (ce_i),
        .in_valid_i (pend_valid),
        .in_data_i  (pend_beat),
        .in_ready_o (fifo_in_ready),
        .out_valid_o(reply_valid_o),
        .out_data_o (reply_beat_o),
        .out_ready_i(reply_ready_i)
    );

endmodule : flbf_formatter

`default_nettype wire

// ===== rtl/flbf_pkg.sv
// types for the fault-log block reply formatter
package flbf_pkg;

    // ----------------
    // stored record preamble fields
    // ----------------
    typedef struct packed {
        logic [7:0]             ptr;
        logic [15:0]            first_fault;
        logic [17:0][15:0]      peak_min;
        logic [7:0][7:0]        status;
    } flbf_record_type;

    // ----------------
    // one reply byte as it leaves the block
    // ----------------
    typedef struct packed {
        logic [7:0]             data;
        logic [8:0]             num;
        logic                   last;
    } flbf_beat_type;

    typedef enum logic [2:0] {
        FLBF_IDLE,
        FLBF_COUNT,
        FLBF_PRE,
        FLBF_LOOP_REQ,
        FLBF_LOOP_WAIT,
        FLBF_LOOP_DATA,
        FLBF_RESV
    } flbf_state_type;

endpackage : flbf_pkg
